// ### core/ifsb_pkg.sv
package ifsb_pkg;

	localparam int unsigned IFSB_DW      = 16;
	localparam int unsigned IFSB_AW      = 2;
	localparam int unsigned IFSB_NBANK   = 4;
	localparam int unsigned IFSB_SRC_W   = 64;

	// Register indices on the plain register port
	localparam logic [1:0] IFSB_BANK0_ADDR = 2'h0;
	localparam logic [1:0] IFSB_BANK1_ADDR = 2'h1;
	localparam logic [1:0] IFSB_BANK2_ADDR = 2'h2;
	localparam logic [1:0] IFSB_BANK3_ADDR = 2'h3;

	// Implemented-bit masks; zeros mark bits with no source
	localparam logic [15:0] IFSB_IMPL0 = 16'h7fff;
	localparam logic [15:0] IFSB_IMPL1 = 16'hffdf;
	localparam logic [15:0] IFSB_IMPL2 = 16'h601f;
	localparam logic [15:0] IFSB_IMPL3 = 16'he600;
	localparam logic [15:0] IFSB_RESET = 16'h0000;

	// Bits of bank 2 fed by the CAN controller
	localparam logic [15:0] IFSB_CAN_BITS = 16'h000c;

	localparam logic [63:0] IFSB_IMPL_ALL = {IFSB_IMPL3, IFSB_IMPL2, IFSB_IMPL1, IFSB_IMPL0};

endpackage

// ### core/ifsb_flag_bank.sv
`timescale 1ns/10ps
// One 16-bit flag register: sticky hardware set, software read/write
module ifsb_flag_bank
	import ifsb_pkg::*;
#(
	parameter logic [15:0] IMPL = 16'hffff
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] set_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] flags_o
);

	import ifsb_pkg::*;

	logic [15:0] flags_reg;
	logic [15:0] flags_next;

	always_comb begin
		flags_next = flags_reg;
		if (wr_i) begin
			flags_next = wdata_i;
		end
		// Hardware set wins over a same-cycle software clear
		flags_next = (flags_next | set_i) & IMPL;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= IFSB_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

	a_set_sticks : assert property (@(posedge clk_i) disable iff (rst_i)
		(|(set_i & IMPL)) |=> ((flags_reg & $past(set_i) & IMPL) == ($past(set_i) & IMPL)))
		else $error("flag set by event did not latch");
	a_unimpl_zero : assert property (@(posedge clk_i) disable iff (rst_i)
		(flags_reg & ~IMPL) == 16'h0000)
		else $error("unimplemented flag bit is set");
	a_hold_idle : assert property (@(posedge clk_i) disable iff (rst_i)
		(!wr_i && set_i == 16'h0000) |=> $stable(flags_reg))
		else $error("flags changed with no cause");

endmodule

// ### core/ifsb_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A flag reads 1 after its source raised a request and 0 while none has occurred.
// - Bits without a source always read zero and ignore writes.
// - Software can read and write each implemented flag, clearing or forcing it.
// - Bank 0 bits 15-8: none, dma1, adc1, uart1 tx, uart1 rx, spi1, spi1 err, timer3.
// - Bank 0 bits 7-0: timer2, cmp2, cap2, dma0, timer1, cmp1, cap1, ext pin 0.
// - Bank 1 bits 15-8: uart2 tx, uart2 rx, ext pin 2, timer5, timer4, cmp4, cmp3, dma2.
// - Bank 1 bits 7-0: cap8, cap7, none, ext pin 1, pin change, comparator, i2c mst, i2c slv.
// - Bank 2: 14 dma4, 13 par port, 12-5 none, 4 dma3, 3 can ev, 2 can rx, 1 spi2, 0 spi2 err.
// - Without a CAN controller the two CAN flags never assert.
// - Bank 3: 15 pwm1 fault a, 14 calendar, 13 dma5, 10 quad dec, 9 pwm1 event, rest none.
//////////////////////////////////////////////////////////////////////////////
module ifsb_top
	import ifsb_pkg::*;
#(
	parameter bit HAS_CAN = 1'b1
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [1:0]        addr_i,
	input  wire logic [15:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [15:0]       rdata_o,
	output logic                   irq_o,
	input  wire logic              dma_ch0_done_flag_i,
	input  wire logic              dma_ch1_done_flag_i,
	input  wire logic              dma_ch2_done_flag_i,
	input  wire logic              dma_ch3_done_flag_i,
	input  wire logic              dma_ch4_done_flag_i,
	input  wire logic              dma_ch5_done_flag_i,
	input  wire logic              adc1_done_flag_i,
	input  wire logic              uart1_tx_flag_i,
	input  wire logic              uart1_rx_flag_i,
	input  wire logic              uart2_tx_flag_i,
	input  wire logic              uart2_rx_flag_i,
	input  wire logic              spi1_event_flag_i,
	input  wire logic              spi1_error_flag_i,
	input  wire logic              spi2_event_flag_i,
	input  wire logic              spi2_error_flag_i,
	input  wire logic              timer1_flag_i,
	input  wire logic              timer2_flag_i,
	input  wire logic              timer3_flag_i,
	input  wire logic              timer4_flag_i,
	input  wire logic              timer5_flag_i,
	input  wire logic              compare1_flag_i,
	input  wire logic              compare2_flag_i,
	input  wire logic              compare3_flag_i,
	input  wire logic              compare4_flag_i,
	input  wire logic              capture1_flag_i,
	input  wire logic              capture2_flag_i,
	input  wire logic              capture7_flag_i,
	input  wire logic              capture8_flag_i,
	input  wire logic              ext_pin0_flag_i,
	input  wire logic              ext_pin1_flag_i,
	input  wire logic              ext_pin2_flag_i,
	input  wire logic              pin_change_flag_i,
	input  wire logic              comparator_flag_i,
	input  wire logic              i2c1_master_flag_i,
	input  wire logic              i2c1_slave_flag_i,
	input  wire logic              parallel_port_flag_i,
	input  wire logic              can_event_flag_i,
	input  wire logic              can_rx_ready_flag_i,
	input  wire logic              pwm1_fault_a_flag_i,
	input  wire logic              calendar_clock_flag_i,
	input  wire logic              quad_decoder1_flag_i,
	input  wire logic              pwm1_event_flag_i
);

	import ifsb_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Event packing into bank positions

	logic [15:0] set0;
	logic [15:0] set1;
	logic [15:0] set2;
	logic [15:0] set3;
	logic [15:0] flags0;
	logic [15:0] flags1;
	logic [15:0] flags2;
	logic [15:0] flags3;
	logic        can_ok;

	// Sources are same-clock logic pulses, so no synchroniser here
	always_comb begin
		can_ok = HAS_CAN;
		set0 = {1'b0, dma_ch1_done_flag_i, adc1_done_flag_i, uart1_tx_flag_i,
			uart1_rx_flag_i, spi1_event_flag_i, spi1_error_flag_i,
			timer3_flag_i,
			timer2_flag_i, compare2_flag_i, capture2_flag_i, dma_ch0_done_flag_i,
			timer1_flag_i, compare1_flag_i, capture1_flag_i,
			ext_pin0_flag_i};
		set1 = {uart2_tx_flag_i, uart2_rx_flag_i, ext_pin2_flag_i, timer5_flag_i,
			timer4_flag_i, compare4_flag_i, compare3_flag_i,
			dma_ch2_done_flag_i,
			capture8_flag_i, capture7_flag_i, 1'b0, ext_pin1_flag_i,
			pin_change_flag_i, comparator_flag_i, i2c1_master_flag_i,
			i2c1_slave_flag_i};
		set2 = {1'b0, dma_ch4_done_flag_i, parallel_port_flag_i, 8'h00,
			dma_ch3_done_flag_i, can_event_flag_i & can_ok,
			can_rx_ready_flag_i & can_ok, spi2_event_flag_i,
			spi2_error_flag_i};
		set3 = {pwm1_fault_a_flag_i, calendar_clock_flag_i, dma_ch5_done_flag_i,
			2'h0, quad_decoder1_flag_i, pwm1_event_flag_i, 9'h000};
	end

	//////////////////////////////////////////////////////////////////////////
	// Flag banks

	// Write strobe decode, shared by the four bank enables
	function automatic logic bank_hit(input logic [1:0] addr, input logic [1:0] idx);
		return addr == idx;
	endfunction

	// Without CAN the two CAN bits are also kept unwritable by software
	localparam logic [15:0] IMPL2_EFF = HAS_CAN ? IFSB_IMPL2 : (IFSB_IMPL2 & ~IFSB_CAN_BITS);

	ifsb_flag_bank #(.IMPL(IFSB_IMPL0)) u_bank0 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (set0),
		.wr_i    (wr_i && bank_hit(addr_i, IFSB_BANK0_ADDR)),
		.wdata_i (wdata_i),
		.flags_o (flags0)
	);

	ifsb_flag_bank #(.IMPL(IFSB_IMPL1)) u_bank1 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (set1),
		.wr_i    (wr_i && bank_hit(addr_i, IFSB_BANK1_ADDR)),
		.wdata_i (wdata_i),
		.flags_o (flags1)
	);

	ifsb_flag_bank #(.IMPL(IMPL2_EFF)) u_bank2 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (set2),
		.wr_i    (wr_i && bank_hit(addr_i, IFSB_BANK2_ADDR)),
		.wdata_i (wdata_i),
		.flags_o (flags2)
	);

	ifsb_flag_bank #(.IMPL(IFSB_IMPL3)) u_bank3 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (set3),
		.wr_i    (wr_i && bank_hit(addr_i, IFSB_BANK3_ADDR)),
		.wdata_i (wdata_i),
		.flags_o (flags3)
	);

	//////////////////////////////////////////////////////////////////////////
	// Read port and request line

	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        irq_reg;
	logic        irq_next;

	always_comb begin
		rdata_next = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				IFSB_BANK0_ADDR: rdata_next = flags0;
				IFSB_BANK1_ADDR: rdata_next = flags1;
				IFSB_BANK2_ADDR: rdata_next = flags2;
				IFSB_BANK3_ADDR: rdata_next = flags3;
				default:         rdata_next = 16'h0000;
			endcase
		end
		// Pending request towards the priority logic; enables live elsewhere
		irq_next = |{flags0, flags1, flags2, flags3};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= IFSB_RESET;
			irq_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg   <= irq_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o   = irq_reg;

	//////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_write_clear0;
		wr_i && addr_i == IFSB_BANK0_ADDR && wdata_i == 16'h0000 && set0 == 16'h0000;
	endsequence

	a_clear_works : assert property (@(posedge clk_i) disable iff (rst_i)
		s_write_clear0 |=> flags0 == 16'h0000)
		else $error("software clear of bank 0 failed");
	// A same-cycle event may add bits to a software write
	a_force_works : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == IFSB_BANK3_ADDR) |=> flags3 == ($past(wdata_i | set3) & IFSB_IMPL3))
		else $error("software write of bank 3 wrong");
	a_read_data : assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == IFSB_BANK1_ADDR) |=> rdata_o == $past(flags1))
		else $error("read data of bank 1 wrong");
	a_unimpl_read : assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i |=> (rdata_o & ~IFSB_IMPL2) == 16'h0000 || $past(addr_i) != IFSB_BANK2_ADDR)
		else $error("unimplemented bank 2 bits read nonzero");
	a_can_off : assert property (@(posedge clk_i) disable iff (rst_i)
		!HAS_CAN |-> (flags2 & IFSB_CAN_BITS) == 16'h0000)
		else $error("CAN flag set without CAN");
	a_set_beats_clear : assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == IFSB_BANK0_ADDR && timer3_flag_i) |=> flags0[8])
		else $error("event lost against clear");
	a_ext0_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		ext_pin0_flag_i |=> flags0[0])
		else $error("ext pin 0 flag not at bit 0");
	a_uart2_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		uart2_tx_flag_i |=> flags1[15])
		else $error("uart2 tx flag not at bit 15");
	a_reset_clear : assert property (@(posedge clk_i)
		rst_i |=> (flags0 | flags1 | flags2 | flags3) == 16'h0000 && !irq_o)
		else $error("flags not clear after reset");
	a_irq_follows : assert property (@(posedge clk_i) disable iff (rst_i)
		(|flags3) |=> irq_o || $past(rst_i))
		else $error("pending flag gave no request");

	// Read data stand one cycle only, and the request line tracks every bank
	a_rdata_idle : assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data present without a read");
	a_read_bank0 : assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == IFSB_BANK0_ADDR) |=> rdata_o == $past(flags0))
		else $error("read data of bank 0 wrong");
	a_read_bank2 : assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == IFSB_BANK2_ADDR) |=> rdata_o == $past(flags2))
		else $error("read data of bank 2 wrong");
	a_read_bank3 : assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == IFSB_BANK3_ADDR) |=> rdata_o == $past(flags3))
		else $error("read data of bank 3 wrong");
	a_irq_level : assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> irq_o == $past(|{flags0, flags1, flags2, flags3}))
		else $error("request line does not match pending flags");

	// Selected sources land on their own bits, whatever software writes that cycle
	a_dma1_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		dma_ch1_done_flag_i |=> flags0[14])
		else $error("dma1 flag not at bit 14");
	a_adc1_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		adc1_done_flag_i |=> flags0[13])
		else $error("adc1 flag not at bit 13");
	a_uart1_rx_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		uart1_rx_flag_i |=> flags0[11])
		else $error("uart1 rx flag not at bit 11");
	a_timer2_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		timer2_flag_i |=> flags0[7])
		else $error("timer2 flag not at bit 7");
	a_cmp4_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		compare4_flag_i |=> flags1[10])
		else $error("compare4 flag not at bit 10");
	a_cap8_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		capture8_flag_i |=> flags1[7])
		else $error("capture8 flag not at bit 7");
	a_pin_change_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		pin_change_flag_i |=> flags1[3])
		else $error("pin change flag not at bit 3");
	a_i2c_slave_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		i2c1_slave_flag_i |=> flags1[0])
		else $error("i2c slave flag not at bit 0");
	a_dma4_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		dma_ch4_done_flag_i |=> flags2[14])
		else $error("dma4 flag not at bit 14");
	a_parport_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		parallel_port_flag_i |=> flags2[13])
		else $error("parallel port flag not at bit 13");
	a_spi2_err_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		spi2_error_flag_i |=> flags2[0])
		else $error("spi2 error flag not at bit 0");
	a_can_rx_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		(HAS_CAN && can_rx_ready_flag_i) |=> flags2[2])
		else $error("can rx flag not at bit 2");
	a_pwm_fault_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		pwm1_fault_a_flag_i |=> flags3[15])
		else $error("pwm1 fault flag not at bit 15");
	a_calendar_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		calendar_clock_flag_i |=> flags3[14])
		else $error("calendar flag not at bit 14");
	a_dma5_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		dma_ch5_done_flag_i |=> flags3[13])
		else $error("dma5 flag not at bit 13");
	a_quad_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		quad_decoder1_flag_i |=> flags3[10])
		else $error("quad decoder flag not at bit 10");
	a_pwm_event_pos : assert property (@(posedge clk_i) disable iff (rst_i)
		pwm1_event_flag_i |=> flags3[9])
		else $error("pwm1 event flag not at bit 9");

endmodule

// ### bench/ifsb_event_src.sv
`timescale 1ns/10ps
// Peripheral event sources, one request line per flag position (bank*16+bit)
module ifsb_event_src (
	input  wire logic        clk_i,
	output logic      [63:0] ev_o
);
	initial ev_o = 64'h0;
	// One-cycle pulse only: the sticky flag must be the sole record of it
	task automatic fire(input int idx);
		@(posedge clk_i) ev_o[idx] <= 1'b1;
		@(posedge clk_i) ev_o[idx] <= 1'b0;
	endtask
endmodule

// ### bench/ifsb_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ifsb_bench;
	import ifsb_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic [1:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] rdata_o;
	logic        irq_o;
	logic [63:0] ev;
	int          miscompares;
	int          tests_run;
	logic [15:0] exp_v;
	logic [15:0] rdata_nc;
	logic        irq_nc;
	logic [15:0] nc_v;

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	ifsb_event_src i_ifsb_event_src (.clk_i(clk_i), .ev_o(ev));

	ifsb_top i_ifsb_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.dma_ch1_done_flag_i(ev[14]), .adc1_done_flag_i(ev[13]), .uart1_tx_flag_i(ev[12]),
		.uart1_rx_flag_i(ev[11]), .spi1_event_flag_i(ev[10]), .spi1_error_flag_i(ev[9]),
		.timer3_flag_i(ev[8]), .timer2_flag_i(ev[7]), .compare2_flag_i(ev[6]),
		.capture2_flag_i(ev[5]), .dma_ch0_done_flag_i(ev[4]), .timer1_flag_i(ev[3]),
		.compare1_flag_i(ev[2]), .capture1_flag_i(ev[1]), .ext_pin0_flag_i(ev[0]),
		.uart2_tx_flag_i(ev[31]), .uart2_rx_flag_i(ev[30]), .ext_pin2_flag_i(ev[29]),
		.timer5_flag_i(ev[28]), .timer4_flag_i(ev[27]), .compare4_flag_i(ev[26]),
		.compare3_flag_i(ev[25]), .dma_ch2_done_flag_i(ev[24]), .capture8_flag_i(ev[23]),
		.capture7_flag_i(ev[22]), .ext_pin1_flag_i(ev[20]), .pin_change_flag_i(ev[19]),
		.comparator_flag_i(ev[18]), .i2c1_master_flag_i(ev[17]),
		.i2c1_slave_flag_i(ev[16]), .dma_ch4_done_flag_i(ev[46]),
		.parallel_port_flag_i(ev[45]), .dma_ch3_done_flag_i(ev[36]),
		.can_event_flag_i(ev[35]), .can_rx_ready_flag_i(ev[34]),
		.spi2_event_flag_i(ev[33]), .spi2_error_flag_i(ev[32]),
		.pwm1_fault_a_flag_i(ev[63]), .calendar_clock_flag_i(ev[62]),
		.dma_ch5_done_flag_i(ev[61]), .quad_decoder1_flag_i(ev[58]),
		.pwm1_event_flag_i(ev[57]));

	// Same banks built without the CAN controller, fed in parallel
	ifsb_top #(.HAS_CAN(1'b0)) i_ifsb_top_nocan (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_nc), .irq_o(irq_nc),
		.dma_ch1_done_flag_i(ev[14]), .adc1_done_flag_i(ev[13]), .uart1_tx_flag_i(ev[12]),
		.uart1_rx_flag_i(ev[11]), .spi1_event_flag_i(ev[10]), .spi1_error_flag_i(ev[9]),
		.timer3_flag_i(ev[8]), .timer2_flag_i(ev[7]), .compare2_flag_i(ev[6]),
		.capture2_flag_i(ev[5]), .dma_ch0_done_flag_i(ev[4]), .timer1_flag_i(ev[3]),
		.compare1_flag_i(ev[2]), .capture1_flag_i(ev[1]), .ext_pin0_flag_i(ev[0]),
		.uart2_tx_flag_i(ev[31]), .uart2_rx_flag_i(ev[30]), .ext_pin2_flag_i(ev[29]),
		.timer5_flag_i(ev[28]), .timer4_flag_i(ev[27]), .compare4_flag_i(ev[26]),
		.compare3_flag_i(ev[25]), .dma_ch2_done_flag_i(ev[24]), .capture8_flag_i(ev[23]),
		.capture7_flag_i(ev[22]), .ext_pin1_flag_i(ev[20]), .pin_change_flag_i(ev[19]),
		.comparator_flag_i(ev[18]), .i2c1_master_flag_i(ev[17]),
		.i2c1_slave_flag_i(ev[16]), .dma_ch4_done_flag_i(ev[46]),
		.parallel_port_flag_i(ev[45]), .dma_ch3_done_flag_i(ev[36]),
		.can_event_flag_i(ev[35]), .can_rx_ready_flag_i(ev[34]),
		.spi2_event_flag_i(ev[33]), .spi2_error_flag_i(ev[32]),
		.pwm1_fault_a_flag_i(ev[63]), .calendar_clock_flag_i(ev[62]),
		.dma_ch5_done_flag_i(ev[61]), .quad_decoder1_flag_i(ev[58]),
		.pwm1_event_flag_i(ev[57]));

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i) begin
			addr_i  <= a;
			wdata_i <= d;
			wr_i    <= 1'b1;
		end
		@(posedge clk_i) wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk_i) begin
			addr_i <= a;
			rd_i   <= 1'b1;
		end
		@(posedge clk_i) rd_i <= 1'b0;
		@(negedge clk_i) d = rdata_o;
		nc_v = rdata_nc;
	endtask

	task finish_test;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		finish_test();
	end

	initial begin
		rst_i   = 1'b1;
		addr_i  = 2'h0;
		wdata_i = 16'h0000;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int b = 0; b < 4; b++) begin
			rd(2'(b), exp_v);
			`CHK(exp_v, 16'h0000)
		end
		`CHK(irq_o, 1'b0)
		$display("test reset values done");
		for (int b = 0; b < 4; b++) begin
			wr(2'(b), 16'hffff);
			rd(2'(b), exp_v);
			`CHK(exp_v, IFSB_IMPL_ALL[b*16 +: 16])
			`CHK(nc_v, IFSB_IMPL_ALL[b*16 +: 16] & ~(b == 2 ? IFSB_CAN_BITS : 16'h0000))
			wr(2'(b), 16'h0000);
			rd(2'(b), exp_v);
			`CHK(exp_v, 16'h0000)
		end
		$display("test software write done");
		// Each source alone must land on its own bit and raise the request line
		for (int n = 0; n < 64; n++) begin
			if (IFSB_IMPL_ALL[n]) begin
				i_ifsb_event_src.fire(n);
				rd(2'(n / 16), exp_v);
				`CHK(exp_v, 16'h0001 << (n % 16))
				`CHK(irq_o, 1'b1)
				`CHK(nc_v, (16'h0001 << (n % 16)) & ~(n / 16 == 2 ? IFSB_CAN_BITS : 16'h0000))
				`CHK(irq_nc, !(n / 16 == 2 && IFSB_CAN_BITS[n % 16]))
				wr(2'(n / 16), 16'h0000);
				rd(2'(n / 16), exp_v);
				`CHK(exp_v, 16'h0000)
			end
		end
		$display("test source mapping done");
		fork
			wr(2'h0, 16'h0000);
			i_ifsb_event_src.fire(8);
		join
		rd(2'h0, exp_v);
		`CHK(exp_v, 16'h0100)
		wr(2'h0, 16'h0000);
		rd(2'h0, exp_v);
		`CHK(exp_v, 16'h0000)
		rd(2'h0, exp_v);
		`CHK(irq_o, 1'b0)
		$display("test set beats clear done");
		// Reset in mid-run must drop flags that are already set
		wr(2'h1, 16'hffff);
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(2'h1, exp_v);
		`CHK(exp_v, 16'h0000)
		`CHK(irq_o, 1'b0)
		$display("test mid-run reset done");
		finish_test();
	end
endmodule
